//--- verilog/bsl_core.sv
// Execution core for compare, skip, branch, move and load instruction groups
`timescale 1ns/1ps
`default_nettype none

module bsl_core
    import bsl_pkg::*;
#(
    parameter int unsigned PC_W = 13
) (
    input  wire logic              clk,
    input  wire logic              rst,
    output logic [PC_W-1:0]        pm_addr,
    input  wire logic [15:0]       pm_rdata,
    output bsl_pkg::bsl_dmem_req_t dm_req,
    input  wire logic [7:0]        dm_rdata,
    output logic [4:0]             io_addr,
    input  wire logic [7:0]        io_rdata,
    input  wire logic              status_wr_en,
    input  wire logic [7:0]        status_wr_data,
    output logic [7:0]             status,
    input  wire logic [4:0]        dbg_reg_sel,
    output logic [7:0]             dbg_reg_data,
    output logic                   instr_done
);
    import bsl_pkg::*;

    bsl_state_t       state_q, state_d;
    logic [PC_W-1:0]  pc_q, pc_d;
    logic [7:0]       status_register_q, status_register_d;
    logic [7:0]       rf_q [32];
    bsl_dec_t         dec;
    logic [15:0]      mem_addr_q, mem_addr_d;
    logic [4:0]       mem_reg_q, mem_reg_d;
    logic             mem_store_q, mem_store_d;
    logic             mem_abs_q, mem_abs_d;
    logic             we8;
    logic [4:0]       wa8;
    logic [7:0]       wd8;
    logic             we16;
    logic [4:0]       wa16;
    logic [15:0]      wd16;
    logic [15:0]      ptr_val;
    logic [7:0]       cmp_res;
    logic [7:0]       rd_v;
    logic             cond;
    logic [PC_W-1:0]  pc_inc;
    logic [PC_W-1:0]  br_tgt;

    // Second word of a two-word instruction must be stepped over as a whole
    function automatic logic two_word(input logic [15:0] w);
        two_word = ((w[15:10] == 6'b100100) && (w[3:0] == 4'h0)) ||
                   ((w[15:9] == 7'b1001010) && (w[3:2] == 2'b11));
    endfunction : two_word

    // Instruction decode from the word at the current program counter
    always_comb begin
        dec        = '0;
        dec.op     = OP_NOP;
        dec.mode   = AM_PLAIN;
        dec.rd     = pm_rdata[8:4];
        dec.rr     = {pm_rdata[9], pm_rdata[3:0]};
        dec.imm    = {pm_rdata[11:8], pm_rdata[3:0]};
        dec.bitsel = pm_rdata[2:0];
        dec.pol    = pm_rdata[9];
        dec.koff   = pm_rdata[9:3];
        dec.io     = pm_rdata[7:3];
        dec.ptr    = PTR_X;
        dec.disp   = {pm_rdata[13], pm_rdata[11:10], pm_rdata[2:0]};
        casez (pm_rdata)
            16'b0011_????_????_????: begin
                dec.op = OP_CMPI;
                dec.rd = {HIGH_BANK, pm_rdata[7:4]};
            end
            16'b1111_11??_????_0???: begin
                dec.op = OP_SKIP_REG;
                dec.rr = pm_rdata[8:4];
            end
            16'b1001_10?1_????_????: dec.op = OP_SKIP_IO;
            16'b1111_0???_????_????: begin
                dec.op  = OP_BRANCH;
                dec.pol = ~pm_rdata[10];
            end
            16'b0010_11??_????_????: dec.op = OP_COPY;
            16'b0000_0001_????_????: begin
                dec.op = OP_PAIR_COPY;
                dec.rd = {pm_rdata[7:4], 1'b0};
                dec.rr = {pm_rdata[3:0], 1'b0};
            end
            16'b1110_????_????_????: begin
                dec.op = OP_CONST;
                dec.rd = {HIGH_BANK, pm_rdata[7:4]};
            end
            16'b1001000?????0000: dec.op = OP_LOAD_ABS;
            16'b1001000?????1100: dec.op = OP_LOAD_IND;
            16'b1001000?????1101: begin
                dec.op   = OP_LOAD_IND;
                dec.mode = AM_POSTINC;
            end
            16'b1001000?????1110: begin
                dec.op   = OP_LOAD_IND;
                dec.mode = AM_PREDEC;
            end
            16'b1001_000?_????_?001: begin
                dec.op   = OP_LOAD_IND;
                dec.mode = AM_POSTINC;
                dec.ptr  = pm_rdata[3] ? PTR_Y : PTR_Z;
            end
            16'b1001_000?_????_?010: begin
                dec.op   = OP_LOAD_IND;
                dec.mode = AM_PREDEC;
                dec.ptr  = pm_rdata[3] ? PTR_Y : PTR_Z;
            end
            16'b10?0_??0?_????_????: begin
                dec.op   = OP_LOAD_IND;
                dec.mode = AM_DISP;
                dec.ptr  = pm_rdata[3] ? PTR_Y : PTR_Z;
            end
            16'b1001001?????1100: begin
                dec.op = OP_STORE_IND;
                dec.rr = pm_rdata[8:4];
            end
            default: dec.op = OP_NOP;
        endcase
    end

    // Operand fetch, compare result and branch target
    assign ptr_val = {rf_q[dec.ptr + 5'h01], rf_q[dec.ptr]};
    assign rd_v    = rf_q[dec.rd];
    assign cmp_res = rd_v - dec.imm;
    assign pc_inc  = pc_q + PC_W'(1);
    // Target is PC+k+1 with a signed seven-bit offset
    assign br_tgt  = pc_inc + {{(PC_W-7){dec.koff[6]}}, dec.koff};
    assign io_addr = dec.io;

    // Aliased branches reduce to a status bit and a polarity
    always_comb begin
        cond = 1'b0;
        case (dec.op)
            OP_SKIP_REG: cond = (rf_q[dec.rr][dec.bitsel] == dec.pol);
            OP_SKIP_IO:  cond = (io_rdata[dec.bitsel] == dec.pol);
            // S holds N xor V, so signed compares test bit S
            OP_BRANCH:   cond = (status_register_q[dec.bitsel] == dec.pol);
            default:     cond = 1'b0;
        endcase
    end

    // Sequencing, register writes and memory setup
    always_comb begin
        state_d     = state_q;
        pc_d        = pc_q;
        status_register_d      = status_register_q;
        mem_addr_d  = mem_addr_q;
        mem_reg_d   = mem_reg_q;
        mem_store_d = mem_store_q;
        mem_abs_d   = mem_abs_q;
        we8         = 1'b0;
        wa8         = dec.rd;
        wd8         = dec.imm;
        we16        = 1'b0;
        wa16        = dec.ptr;
        wd16        = ptr_val;
        instr_done  = 1'b0;
        case (state_q)
            ST_EXEC: begin
                pc_d       = pc_inc;
                instr_done = 1'b1;
                case (dec.op)
                    OP_CMPI: begin
                        // Result is discarded, only flags change
                        status_register_d[SF_Z] = (cmp_res == 8'h00);
                        status_register_d[SF_N] = cmp_res[7];
                        status_register_d[SF_V] = (rd_v[7] & ~dec.imm[7] & ~cmp_res[7]) |
                                       (~rd_v[7] & dec.imm[7] & cmp_res[7]);
                        status_register_d[SF_C] = (~rd_v[7] & dec.imm[7]) | (dec.imm[7] & cmp_res[7]) |
                                       (cmp_res[7] & ~rd_v[7]);
                        status_register_d[SF_H] = (~rd_v[3] & dec.imm[3]) | (dec.imm[3] & cmp_res[3]) |
                                       (cmp_res[3] & ~rd_v[3]);
                        status_register_d[SF_S] = status_register_d[SF_N] ^ status_register_d[SF_V];
                    end
                    OP_SKIP_REG, OP_SKIP_IO: begin
                        if (cond) begin
                            state_d    = ST_SKIP;
                            instr_done = 1'b0;
                        end
                    end
                    OP_BRANCH: begin
                        if (cond) begin
                            pc_d       = br_tgt;
                            state_d    = ST_BRANCH;
                            instr_done = 1'b0;
                        end
                    end
                    OP_COPY: begin
                        we8 = 1'b1;
                        wd8 = rf_q[dec.rr];
                    end
                    OP_PAIR_COPY: begin
                        we16 = 1'b1;
                        wa16 = dec.rd;
                        wd16 = {rf_q[dec.rr + 5'h01], rf_q[dec.rr]};
                    end
                    OP_CONST: we8 = 1'b1;
                    OP_LOAD_IND, OP_STORE_IND: begin
                        state_d     = ST_MEM;
                        instr_done  = 1'b0;
                        mem_abs_d   = 1'b0;
                        mem_store_d = (dec.op == OP_STORE_IND);
                        mem_reg_d   = (dec.op == OP_STORE_IND) ? dec.rr : dec.rd;
                        mem_addr_d  = ptr_val;
                        case (dec.mode)
                            AM_POSTINC: begin
                                we16 = 1'b1;
                                wd16 = ptr_val + 16'h0001;
                            end
                            AM_PREDEC: begin
                                we16       = 1'b1;
                                wd16       = ptr_val - 16'h0001;
                                mem_addr_d = ptr_val - 16'h0001;
                            end
                            AM_DISP: mem_addr_d = ptr_val + {10'h000, dec.disp};
                            default: mem_addr_d = ptr_val;
                        endcase
                    end
                    OP_LOAD_ABS: begin
                        state_d     = ST_MEM;
                        instr_done  = 1'b0;
                        mem_abs_d   = 1'b1;
                        mem_store_d = 1'b0;
                        mem_reg_d   = dec.rd;
                    end
                    default: ;
                endcase
            end
            ST_MEM: begin
                // Absolute address is the second word, now at the program counter
                if (mem_abs_q) begin
                    pc_d = pc_inc;
                end
                we8        = ~mem_store_q;
                wa8        = mem_reg_q;
                wd8        = dm_rdata;
                instr_done = 1'b1;
                state_d    = ST_EXEC;
            end
            ST_BRANCH: begin
                instr_done = 1'b1;
                state_d    = ST_EXEC;
            end
            ST_SKIP: begin
                // Word now at the program counter is the one being skipped
                pc_d = pc_inc;
                if (two_word(pm_rdata)) begin
                    state_d = ST_SKIP_LONG;
                end else begin
                    state_d    = ST_EXEC;
                    instr_done = 1'b1;
                end
            end
            ST_SKIP_LONG: begin
                pc_d       = pc_inc;
                instr_done = 1'b1;
                state_d    = ST_EXEC;
            end
            default: state_d = ST_EXEC;
        endcase
        // External flag preset wins over any flag result in the same cycle
        if (status_wr_en) begin
            status_register_d = status_wr_data;
        end
    end

    // Memory request is live only in the access cycle
    always_comb begin
        dm_req       = '0;
        dm_req.addr  = mem_abs_q ? pm_rdata : mem_addr_q;
        dm_req.wdata = rf_q[mem_reg_q];
        dm_req.re    = (state_q == ST_MEM) & ~mem_store_q;
        dm_req.we    = (state_q == ST_MEM) & mem_store_q;
    end

    assign pm_addr = pc_q;
    assign status  = status_register_q;

    // Sequencer state and program counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_EXEC;
            pc_q    <= '0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    // Status flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_register_q <= STATUS_RST;
        end else begin
            status_register_q <= status_register_d;
        end
    end

    // Pending memory access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr_q  <= '0;
            mem_reg_q   <= '0;
            mem_store_q <= 1'b0;
            mem_abs_q   <= 1'b0;
        end else begin
            mem_addr_q  <= mem_addr_d;
            mem_reg_q   <= mem_reg_d;
            mem_store_q <= mem_store_d;
            mem_abs_q   <= mem_abs_d;
        end
    end

    // Working registers; byte write after pair write so a load wins a clash
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= REG_RST;
            end
        end else begin
            if (we16) begin
                rf_q[wa16]         <= wd16[7:0];
                rf_q[wa16 + 5'h01] <= wd16[15:8];
            end
            if (we8) begin
                rf_q[wa8] <= wd8;
            end
        end
    end

    // Debug read-back, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbg_reg_data <= 8'h00;
        end else begin
            dbg_reg_data <= rf_q[dbg_reg_sel];
        end
    end

endmodule : bsl_core

`default_nettype wire

//--- verilog/bsl_pkg.sv
// Constants, encodings and carrier types for the branch, skip and load execution core
package bsl_pkg;

    // Status register bit positions
    localparam int unsigned SF_C = 0;
    localparam int unsigned SF_Z = 1;
    localparam int unsigned SF_N = 2;
    localparam int unsigned SF_V = 3;
    localparam int unsigned SF_S = 4;
    localparam int unsigned SF_H = 5;
    localparam int unsigned SF_T = 6;
    localparam int unsigned SF_I = 7;

    // Reset values
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  REG_RST    = 8'h00;

    // Low register index of each pointer pair
    localparam logic [4:0]  PTR_X = 5'h1A;
    localparam logic [4:0]  PTR_Y = 5'h1C;
    localparam logic [4:0]  PTR_Z = 5'h1E;

    // Upper-half base for immediate-capable destinations
    localparam logic        HIGH_BANK = 1'b1;

    // Execution states
    typedef enum logic [2:0] {
        ST_EXEC      = 3'b000,
        ST_MEM       = 3'b001,
        ST_BRANCH    = 3'b010,
        ST_SKIP      = 3'b011,
        ST_SKIP_LONG = 3'b100
    } bsl_state_t;

    // Decoded operation classes
    typedef enum logic [3:0] {
        OP_NOP        = 4'b0000,
        OP_CMPI       = 4'b0001,
        OP_SKIP_REG   = 4'b0010,
        OP_SKIP_IO    = 4'b0011,
        OP_BRANCH     = 4'b0100,
        OP_COPY       = 4'b0101,
        OP_PAIR_COPY  = 4'b0110,
        OP_CONST      = 4'b0111,
        OP_LOAD_IND   = 4'b1000,
        OP_LOAD_ABS   = 4'b1001,
        OP_STORE_IND  = 4'b1010
    } bsl_op_t;

    // Pointer addressing modes
    typedef enum logic [1:0] {
        AM_PLAIN   = 2'b00,
        AM_POSTINC = 2'b01,
        AM_PREDEC  = 2'b10,
        AM_DISP    = 2'b11
    } bsl_amode_t;

    // Decoded instruction fields
    typedef struct packed {
        bsl_op_t    op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [2:0] bitsel;
        logic       pol;
        logic [4:0] ptr;
        bsl_amode_t mode;
        logic [5:0] disp;
        logic [6:0] koff;
        logic [4:0] io;
    } bsl_dec_t;

    // Data memory request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } bsl_dmem_req_t;

endpackage : bsl_pkg

//--- bench/bsl_core_monitor.sv
// Concurrent checks on the ports of the execution core
`timescale 1ns/1ps
`default_nettype none
module bsl_core_monitor
    import bsl_pkg::*;
#(
    parameter int unsigned PC_W = 13
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [PC_W-1:0]        pm_addr,
    input  wire logic [15:0]            pm_rdata,
    input  wire bsl_pkg::bsl_dmem_req_t dm_req,
    input  wire logic [4:0]             io_addr,
    input  wire logic [7:0]             io_rdata,
    input  wire logic                   status_wr_en,
    input  wire logic [7:0]             status,
    input  wire logic                   instr_done
);
    logic            first_q;
    logic            cmp_go;
    logic            one_go;
    logic            br_go;
    logic            io_go;
    logic            abs_go;
    logic            ld_go;
    logic            st_go;
    logic [PC_W-1:0] br_tgt;

    // A new instruction starts after one ended; reset counts as ended
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= instr_done;
        end
    end

    // Opcode classes, only in a first cycle so skipped words are ignored
    assign cmp_go = first_q && pm_rdata[15:12] == 4'h3;
    assign one_go = cmp_go || first_q && (pm_rdata[15:12] == 4'hE
                    || pm_rdata[15:10] == 6'h0B || pm_rdata[15:8] == 8'h01);
    assign br_go  = first_q && pm_rdata[15:11] == 5'h1E;
    assign io_go  = first_q && pm_rdata[15:10] == 6'h26 && pm_rdata[8];
    assign abs_go = first_q && pm_rdata[15:9] == 7'h48 && pm_rdata[3:0] == 4'h0;
    assign ld_go  = first_q && (pm_rdata[15:9] == 7'h48
                    && pm_rdata[3:0] inside {4'h1, 4'h2, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE}
                    || pm_rdata[15:14] == 2'h2 && !pm_rdata[12] && !pm_rdata[9]);
    assign st_go  = first_q && pm_rdata[15:9] == 7'h49 && pm_rdata[3:0] == 4'hC;
    // Offset is signed, so it is widened by its sign bit
    assign br_tgt = pm_addr + {{(PC_W-7){pm_rdata[9]}}, pm_rdata[9:3]} + PC_W'(1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    one_cycle_a: assert property (one_go |-> instr_done && !dm_req.re && !dm_req.we)
        else $error("single-cycle instruction overran or used memory");
    flags_hold_a: assert property (!$stable(status) |-> $past(status_wr_en) || $past(cmp_go))
        else $error("status changed outside compare or preset");
    branch_cond_a: assert property (br_go |-> instr_done == (status[pm_rdata[2:0]] == pm_rdata[10]))
        else $error("branch decision disagrees with status bit");
    branch_target_a: assert property (br_go && !instr_done |=> instr_done && pm_addr == $past(br_tgt))
        else $error("taken branch wrong target or length");
    io_skip_a: assert property (io_go |-> io_addr == pm_rdata[7:3]
        && instr_done == (io_rdata[pm_rdata[2:0]] != pm_rdata[9]))
        else $error("io bit skip decision wrong");
    abs_load_a: assert property (abs_go |-> !instr_done ##1 (instr_done && dm_req.re && dm_req.addr == pm_rdata && pm_addr == $past(pm_addr) + PC_W'(1)))
        else $error("absolute load address or timing wrong");
    ptr_load_a: assert property (ld_go |-> !instr_done ##1 (instr_done && dm_req.re && !dm_req.we) ##1 !dm_req.re)
        else $error("pointer load timing wrong");
    ptr_store_a: assert property (st_go |-> !instr_done ##1 (instr_done && dm_req.we && !dm_req.re))
        else $error("pointer store timing wrong");
endmodule : bsl_core_monitor

bind bsl_core bsl_core_monitor #(.PC_W(PC_W)) u_bsl_core_monitor (
    .clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_req(dm_req),
    .io_addr(io_addr), .io_rdata(io_rdata), .status_wr_en(status_wr_en),
    .status(status), .instr_done(instr_done)
);
`default_nettype wire

//--- bench/bsl_mem_model.sv
// Program, data and I/O memories on the far side of the execution core
`timescale 1ns/1ps
`default_nettype none
module bsl_mem_model
    import bsl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [12:0]            pm_addr,
    output logic [15:0]                 pm_rdata,
    input  wire bsl_pkg::bsl_dmem_req_t dm_req,
    output logic [7:0]                  dm_rdata,
    input  wire logic [4:0]             io_addr,
    output logic [7:0]                  io_rdata
);
    logic [15:0] pmem [256];
    logic [7:0]  dmem [256];
    logic [7:0]  ioreg [32];

    // Bytes hold address xor A5 so every location reads differently
    initial begin
        for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'hA5;
        for (int i = 0; i < 32; i++) ioreg[i] = 8'(i) << 1;
    end

    // Async reads; an idle data port shows the inverse, never a stale byte
    assign pm_rdata = pmem[pm_addr[7:0]];
    assign dm_rdata = dm_req.re ? dmem[dm_req.addr[7:0]] : ~dmem[dm_req.addr[7:0]];
    assign io_rdata = ioreg[io_addr];

    // Store lands at the edge that closes the write cycle
    always @(posedge clk) begin
        if (dm_req.we) begin
            dmem[dm_req.addr[7:0]] <= dm_req.wdata;
        end
    end
endmodule : bsl_mem_model
`default_nettype wire

//--- bench/test_branch_skip_load_execute.sv
// Self-checking bench for the branch, skip and load execution core
`timescale 1ns/1ps
`default_nettype none
module test_branch_skip_load_execute;
    import bsl_pkg::*;
    localparam int B = 42;
    logic          clk;
    logic          rst;
    logic [12:0]   pm_addr;
    logic [15:0]   pm_rdata;
    bsl_dmem_req_t dm_req;
    logic [7:0]    dm_rdata;
    logic [4:0]    io_addr;
    logic [7:0]    io_rdata;
    logic          status_wr_en;
    logic [7:0]    status_wr_data;
    logic [7:0]    status;
    logic [4:0]    dbg_reg_sel;
    logic [7:0]    dbg_reg_data;
    logic          instr_done;
    int            bad_count;
    int            compares;
    // Branch cases: [15:13] flag, [12] clear variant, [11:4] preset, [0] taken
    logic [15:0] brt [14] = '{16'h2021, 16'h3020, 16'h0000, 16'h1001, 16'h4041, 16'h5040,
        16'h9180, 16'h8181, 16'hA201, 16'hB001, 16'hC000, 16'hE801, 16'hF800, 16'h6081};
    // Compare, copy, skip, load and store program ending in a self loop
    logic [15:0] prog [34] = '{16'hE400, 16'h3401, 16'hE810, 16'h3011, 16'hF00C, 16'h0000,
        16'h3400, 16'h2E20, 16'hE1A0, 16'hE0B0, 16'h01FD, 16'hFF06, 16'hEF2F, 16'hFD06,
        16'hFD00, 16'h9120, 16'h0020, 16'h9B2B, 16'h0000, 16'h992B, 16'h913D, 16'h9142,
        16'h8152, 16'h9160, 16'h0030, 16'h933C, 16'h917C, 16'h918E, 16'hE2C0, 16'h9199,
        16'h800B, 16'h9011, 16'h903A, 16'hF7FF};
    int offs [29] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 13, 14, 17, 19, 20, 21, 22, 23,
        25, 26, 27, 28, 29, 30, 31, 32, 33, 33};
    int cycs [29] = '{1, 1, 1, 1, 2, 1, 1, 1, 1, 1, 2, 1, 3, 2, 1, 2, 2, 2, 2, 2, 2,
        2, 1, 2, 2, 2, 2, 2, 2};
    logic [7:0] sts [29] = '{8'h08, 8'h35, 8'h35, 8'h38, 8'h38, 8'h02, 8'h02, 8'h02, 8'h02,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    // Register index and final value; loaded bytes are address xor A5, except r23, which reads back the B5 stored at 0x11
    logic [15:0] regs [20] = '{16'h1040, 16'h1180, 16'h0240, 16'h1200, 16'h13B5, 16'h14AA,
        16'h15B4, 16'h1695, 16'h17B5, 16'h1A10, 16'h1B00, 16'h1E10, 16'h1F00, 16'h18B5,
        16'h1C20, 16'h1D00, 16'h1985, 16'h0081, 16'h01AA, 16'h0385};

    bsl_core u_bsl_core (
        .clk(clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_req(dm_req),
        .dm_rdata(dm_rdata), .io_addr(io_addr), .io_rdata(io_rdata),
        .status_wr_en(status_wr_en), .status_wr_data(status_wr_data), .status(status),
        .dbg_reg_sel(dbg_reg_sel), .dbg_reg_data(dbg_reg_data), .instr_done(instr_done)
    );
    bsl_mem_model u_bsl_mem_model (
        .clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_req(dm_req),
        .dm_rdata(dm_rdata), .io_addr(io_addr), .io_rdata(io_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Runs one instruction from its first cycle to the next one's first cycle
    task automatic step(input int pc, input int cyc, input logic [8:0] sw);
        int n;
        status_wr_en = sw[8];
        status_wr_data = sw[7:0];
        n = 1;
        check(16'(pm_addr), 16'(pc));
        while (instr_done !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        check(16'(n), 16'(cyc));
        @(negedge clk);
    endtask : step

    // Read-back port is registered, so the value shows one cycle later
    task automatic rd(input logic [4:0] sel, input logic [7:0] exp);
        dbg_reg_sel = sel;
        @(negedge clk);
        check(16'(dbg_reg_data), 16'(exp));
    endtask : rd

    task automatic finish_test;
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Hang guard, far beyond the roughly 120 cycles the run needs
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        status_wr_en = 1'b0;
        status_wr_data = 8'h00;
        dbg_reg_sel = 5'h00;
        bad_count = 0;
        compares = 0;
        for (int i = 0; i < 256; i++) u_bsl_mem_model.pmem[i] = 16'h0000;
        foreach (brt[i]) u_bsl_mem_model.pmem[3*i+1] = {5'h1E, brt[i][12], 7'h01, brt[i][15:13]};
        foreach (prog[i]) u_bsl_mem_model.pmem[B+i] = prog[i];
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // Each case: preset status on a no-op, then branch over one word
        foreach (brt[i]) begin
            step(3*i, 1, {1'b1, brt[i][11:4]});
            step(3*i+1, brt[i][0] ? 2 : 1, 9'h000);
            check(16'(status), 16'(brt[i][11:4]));
            if (brt[i][0] == 1'b0) step(3*i+2, 1, 9'h000);
        end
        foreach (offs[i]) begin
            step(B+offs[i], cycs[i], 9'h000);
            check(16'(status), 16'(sts[i]));
        end
        foreach (regs[i]) rd(regs[i][12:8], regs[i][7:0]);
        check(16'(u_bsl_mem_model.dmem[8'h11]), 16'h00B5);
        finish_test();
    end
endmodule : test_branch_skip_load_execute
`default_nettype wire
